// *** srse_exec.v ***
// execution unit for rotate right, three subtracts and sleep
// Operation
// RULE1 - a destination bit of 0 sends the result to W and 1 to the file register.
// RULE2 - rotate right moves carry into bit 7, bit 0 into carry, and changes only carry.
// RULE3 - subtract-from-literal computes literal minus W into W and updates C, DC and Z.
// RULE4 - subtract-from-file computes file minus W to the destination and updates C, DC, Z.
// RULE5 - subtract-with-borrow also subtracts the inverted carry and updates C, DC, Z.
// RULE6 - rotate results go back to the file register when the destination bit is set.
// RULE7 - sleep clears the power-down flag.
// RULE8 - sleep sets the time-out flag.
// RULE9 - sleep clears the watchdog counter to zero and clears its prescaler; the code only pulses watchdog_clear for one cycle.
// RULE10 - after sleep, execution halts and the oscillator stops until a wake.
// RULE11 - subtract carry means no borrow, digit carry no nibble borrow, zero a zero result.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "srse_consts.vh"
module srse_exec #(
   parameter WIDTH = 8
) (
   input wire core_clk,
   input wire nrst,
   input wire op_valid,
   input wire [2:0] op_code,
   input wire dest_sel,
   input wire [WIDTH-1:0] literal_in,
   input wire [WIDTH-1:0] file_rd_data,
   input wire wake_event,
   output reg [WIDTH-1:0] w_reg,
   output reg [WIDTH-1:0] file_wr_data,
   output reg file_wr_en,
   output reg carry_flag,
   output reg digit_carry_flag,
   output reg zero_flag,
   output reg power_down_flag,
   output reg time_out_flag,
   output reg watchdog_clear,
   output reg sleep_active,
   output wire osc_run,
   output wire exec_ready
);
   // one-hot core state
   localparam ST_RUN = 2'h1;
   localparam ST_SLEEP = 2'h2;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg wake_meta_reg;
   reg wake_sync_reg;

   wire [WIDTH-1:0] sub_a;
   wire [WIDTH-1:0] sub_diff;
   wire sub_c;
   wire sub_dc;
   wire sub_z;
   wire sub_cin;
   wire [WIDTH-1:0] rot_result;
   wire run_op;

   assign run_op = op_valid && (state_reg == ST_RUN);
   assign exec_ready = (state_reg == ST_RUN);
   assign osc_run = (state_reg == ST_RUN); // [RULE10]

   assign sub_a = (op_code == `SRSE_OP_SUB_LITERAL) ? literal_in : file_rd_data; // [RULE3]
   // plain subtracts inject carry 1, the borrow form uses the live carry
   assign sub_cin = (op_code == `SRSE_OP_SUB_BORROW) ? carry_flag : 1'b1; // [RULE5]
   assign rot_result = {carry_flag, file_rd_data[WIDTH-1:1]}; // [RULE2]

   srse_sub_unit #(
      .WIDTH(WIDTH)
   ) u_sub (
      .minuend(sub_a),
      .subtrahend(w_reg),
      .carry_in(sub_cin),
      .diff(sub_diff),
      .carry_out(sub_c),
      .digit_carry_out(sub_dc),
      .zero_out(sub_z)
   );

   // wake is an outside level, synchronise before use
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
      end else begin
         wake_meta_reg <= wake_event;
         wake_sync_reg <= wake_meta_reg;
      end
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (run_op && op_code == `SRSE_OP_SLEEP)
               state_next = ST_SLEEP; // [RULE10]
         end
         ST_SLEEP: begin
            if (wake_sync_reg)
               state_next = ST_RUN;
         end
         default: state_next = ST_RUN;
      endcase
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_RUN;
         w_reg <= `SRSE_W_RESET;
         file_wr_data <= {WIDTH{1'b0}};
         file_wr_en <= 1'b0;
         carry_flag <= `SRSE_CARRY_RESET;
         digit_carry_flag <= 1'b0;
         zero_flag <= 1'b0;
         power_down_flag <= `SRSE_PD_RESET;
         time_out_flag <= `SRSE_TO_RESET;
         watchdog_clear <= 1'b0;
         sleep_active <= 1'b0;
      end else begin
         state_reg <= state_next;
         sleep_active <= (state_next == ST_SLEEP); // [RULE10]
         file_wr_en <= 1'b0;
         watchdog_clear <= 1'b0;
         if (run_op) begin
            case (op_code)
               `SRSE_OP_ROTATE_RIGHT: begin
                  carry_flag <= file_rd_data[0]; // [RULE2]
                  if (dest_sel == `SRSE_DEST_FILE) begin
                     file_wr_data <= rot_result; // [RULE6]
                     file_wr_en <= 1'b1; // [RULE6]
                  end else begin
                     w_reg <= rot_result; // [RULE1]
                  end
               end
               `SRSE_OP_SUB_LITERAL: begin
                  w_reg <= sub_diff; // [RULE3]
                  carry_flag <= sub_c;
                  digit_carry_flag <= sub_dc;
                  zero_flag <= sub_z;
               end
               `SRSE_OP_SUB_FILE,
               `SRSE_OP_SUB_BORROW: begin
                  carry_flag <= sub_c; // [RULE4] [RULE5]
                  digit_carry_flag <= sub_dc; // [RULE4] [RULE5]
                  zero_flag <= sub_z; // [RULE4] [RULE5]
                  if (dest_sel == `SRSE_DEST_FILE) begin
                     file_wr_data <= sub_diff; // [RULE1]
                     file_wr_en <= 1'b1; // [RULE1]
                  end else begin
                     w_reg <= sub_diff; // [RULE1]
                  end
               end
               `SRSE_OP_SLEEP: begin
                  power_down_flag <= 1'b0; // [RULE7]
                  time_out_flag <= 1'b1; // [RULE8]
                  watchdog_clear <= 1'b1; // [RULE9]
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule // srse_exec
`default_nettype wire

// *** srse_consts.vh ***
// constants for the subtract / rotate / sleep execution block
`ifndef SRSE_CONSTS_VH
`define SRSE_CONSTS_VH
`define SRSE_OP_NONE 3'h0
`define SRSE_OP_ROTATE_RIGHT 3'h1
`define SRSE_OP_SUB_LITERAL 3'h2
`define SRSE_OP_SUB_FILE 3'h3
`define SRSE_OP_SUB_BORROW 3'h4
`define SRSE_OP_SLEEP 3'h5
`define SRSE_DEST_W 1'h0
`define SRSE_DEST_FILE 1'h1
`define SRSE_W_RESET 8'h00
`define SRSE_WDT_CLEAR 8'h00
`define SRSE_PRESCALE_CLEAR 8'h00
`define SRSE_CARRY_RESET 1'h0
`define SRSE_PD_RESET 1'h1
`define SRSE_TO_RESET 1'h1
`endif

// *** srse_sub_unit.v ***
// subtractor with borrow-style carry, digit carry and zero outputs
`timescale 1ns/100ps
`default_nettype none
module srse_sub_unit #(
   parameter WIDTH = 8
) (
   input wire [WIDTH-1:0] minuend,
   input wire [WIDTH-1:0] subtrahend,
   input wire carry_in,
   output wire [WIDTH-1:0] diff,
   output wire carry_out,
   output wire digit_carry_out,
   output wire zero_out
);
   // a - b - !c == a + ~b + c; carry out high means no borrow
   wire [WIDTH:0] full_sum;
   wire [4:0] low_sum;
   assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carry_in}; // [RULE11]
   assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in}; // [RULE11]
   assign diff = full_sum[WIDTH-1:0];
   assign carry_out = full_sum[WIDTH]; // [RULE11]
   assign digit_carry_out = low_sum[4]; // [RULE11]
   assign zero_out = (full_sum[WIDTH-1:0] == {WIDTH{1'b0}}); // [RULE11]
endmodule // srse_sub_unit
`default_nettype wire

// *** srse_exec_properties.sv ***
// port assertions for srse_exec
`timescale 1ns/100ps
`default_nettype none
module srse_exec_props (
   input wire core_clk,
   input wire nrst,
   input wire op_valid,
   input wire [2:0] op_code,
   input wire dest_sel,
   input wire [7:0] literal_in,
   input wire [7:0] file_rd_data,
   input wire [7:0] w_reg,
   input wire [7:0] file_wr_data,
   input wire file_wr_en,
   input wire carry_flag,
   input wire power_down_flag,
   input wire time_out_flag,
   input wire watchdog_clear,
   input wire sleep_active,
   input wire osc_run,
   input wire exec_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire go = op_valid & exec_ready;
   wire slp = go & (op_code == 3'h5);
   wire rot = go & (op_code == 3'h1);
   pd_clear_a: assert property (slp |=> !power_down_flag)
      else $error("pd not cleared");
   to_set_a: assert property (slp |=> time_out_flag)
      else $error("to not set");
   wdt_clear_a: assert property (slp |=> watchdog_clear)
      else $error("no watchdog clear");
   sleep_halt_a: assert property (slp |=> sleep_active && !osc_run
      && !exec_ready) else $error("no halt");
   rot_file_a: assert property (rot && dest_sel |=> file_wr_en &&
      file_wr_data == {$past(carry_flag), $past(file_rd_data[7:1])})
      else $error("rotate write");
   rot_carry_a: assert property (rot |=>
      carry_flag == $past(file_rd_data[0])) else $error("rotate carry");
   subl_w_a: assert property (go && op_code == 3'h2 |=>
      w_reg == $past(literal_in) - $past(w_reg)) else $error("sub lit");
   sub_w_a: assert property (go && op_code == 3'h3 && !dest_sel |=>
      !file_wr_en && w_reg == $past(file_rd_data) - $past(w_reg))
      else $error("sub file");
endmodule // srse_exec_props
`default_nettype wire

// *** srse_exec_test.sv ***
// self-checking bench for srse_exec
`timescale 1ns/100ps
`default_nettype none
module srse_exec_test;
   reg core_clk = 1'b0;
   reg nrst = 1'b0;
   reg op_valid = 1'b0;
   reg [2:0] op_code = 3'h0;
   reg dest_sel = 1'b0;
   reg [7:0] literal_in = 8'h00;
   reg [7:0] file_rd_data = 8'h00;
   reg wake_event = 1'b0;
   wire [7:0] w_reg, file_wr_data;
   wire file_wr_en, carry_flag, digit_carry_flag, zero_flag, power_down_flag;
   wire time_out_flag, watchdog_clear, sleep_active, osc_run, exec_ready;
   // flags packed so one compare covers every status output except osc_run and exec_ready
   wire [7:0] st = {file_wr_en, watchdog_clear, sleep_active, power_down_flag,
      time_out_flag, carry_flag, digit_carry_flag, zero_flag};
   integer bad_count = 0;
   integer tests_run = 0;
   integer n;
   always #50 core_clk = ~core_clk;
   srse_exec srse_exec_i (
      .core_clk(core_clk),
      .nrst(nrst),
      .op_valid(op_valid),
      .op_code(op_code),
      .dest_sel(dest_sel),
      .literal_in(literal_in),
      .file_rd_data(file_rd_data),
      .wake_event(wake_event),
      .w_reg(w_reg),
      .file_wr_data(file_wr_data),
      .file_wr_en(file_wr_en),
      .carry_flag(carry_flag),
      .digit_carry_flag(digit_carry_flag),
      .zero_flag(zero_flag),
      .power_down_flag(power_down_flag),
      .time_out_flag(time_out_flag),
      .watchdog_clear(watchdog_clear),
      .sleep_active(sleep_active),
      .osc_run(osc_run),
      .exec_ready(exec_ready)
   );
   task ck(input [7:0] e, input [7:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task op(input [2:0] c, input d, input [7:0] l, input [7:0] f,
      input [7:0] ew, input [7:0] es);
      begin
         @(posedge core_clk);
         op_valid <= 1'b1;
         op_code <= c;
         dest_sel <= d;
         literal_in <= l;
         file_rd_data <= f;
         @(posedge core_clk);
         op_valid <= 1'b0;
         #10;
         ck(ew, w_reg);
         ck(es, st);
         $display("op %0d done", c);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      #10;
      ck(8'h18, st);
      op(3'h2, 1'b0, 8'h05, 8'h00, 8'h05, 8'h1e);
      op(3'h2, 1'b0, 8'h03, 8'h00, 8'hfe, 8'h18);
      op(3'h3, 1'b0, 8'h00, 8'hfe, 8'h00, 8'h1f);
      op(3'h3, 1'b1, 8'h00, 8'h10, 8'h00, 8'h9e);
      ck(8'h10, file_wr_data);
      op(3'h2, 1'b0, 8'h01, 8'h00, 8'h01, 8'h1e);
      op(3'h4, 1'b0, 8'h00, 8'h00, 8'hff, 8'h18);
      op(3'h4, 1'b0, 8'h00, 8'h05, 8'h05, 8'h18);
      op(3'h1, 1'b1, 8'h00, 8'h81, 8'h05, 8'h9c);
      ck(8'h40, file_wr_data);
      op(3'h1, 1'b0, 8'h00, 8'h02, 8'h81, 8'h18);
      op(3'h5, 1'b0, 8'h00, 8'h00, 8'h81, 8'h68);
      op(3'h2, 1'b0, 8'h22, 8'h00, 8'h81, 8'h28);
      ck(8'h00, {6'h00, osc_run, exec_ready});
      @(posedge core_clk);
      wake_event <= 1'b1;
      for (n = 0; n < 10 && exec_ready !== 1'b1; n = n + 1)
         @(posedge core_clk);
      #10;
      ck(8'h03, {6'h00, osc_run, exec_ready});
      @(posedge core_clk);
      wake_event <= 1'b0;
      op(3'h2, 1'b0, 8'h81, 8'h00, 8'h00, 8'h0f);
      wrap_up;
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      wrap_up;
   end
endmodule // srse_exec_test
bind srse_exec srse_exec_props srse_exec_props_i (
   .core_clk(core_clk),
   .nrst(nrst),
   .op_valid(op_valid),
   .op_code(op_code),
   .dest_sel(dest_sel),
   .literal_in(literal_in),
   .file_rd_data(file_rd_data),
   .w_reg(w_reg),
   .file_wr_data(file_wr_data),
   .file_wr_en(file_wr_en),
   .carry_flag(carry_flag),
   .power_down_flag(power_down_flag),
   .time_out_flag(time_out_flag),
   .watchdog_clear(watchdog_clear),
   .sleep_active(sleep_active),
   .osc_run(osc_run),
   .exec_ready(exec_ready)
);
`default_nettype wire
